// ### include/srn_pkg.sv
// Package for the sublink rate notifier: field layout, codes and types
package srn_pkg;

    // ----------------------------------------
    // Dword 0 layout
    // ----------------------------------------
    localparam int TYPE_LSB = 0;
    localparam int TYPE_W = 5;
    localparam int DEV_ADDR_LSB = 25;
    localparam int DEV_ADDR_W = 7;
    localparam logic [TYPE_W-1:0] TP_TYPE_CODE = 5'h04;

    // ----------------------------------------
    // Dword 1 layout
    // ----------------------------------------
    localparam int SUBTYPE_LSB = 0;
    localparam int NOTE_TYPE_LSB = 4;
    localparam int CODE_W = 4;
    localparam int FOLLOW_BIT = 31;
    localparam logic [CODE_W-1:0] DEVICE_NOTICE_SUBTYPE = 4'h4;
    localparam logic [CODE_W-1:0] SUBLINK_SPEED_NOTE = 4'h6;

    // ----------------------------------------
    // Dword 2 layout
    // ----------------------------------------
    localparam int EXPONENT_LSB = 4;
    localparam int EXPONENT_W = 2;
    localparam int SUBLINK_TYPE_LSB = 6;
    localparam int SUBLINK_TYPE_W = 2;
    localparam int LANES_LSB = 10;
    localparam int LANES_W = 4;
    localparam int LINK_PROTOCOL_LSB = 14;
    localparam int LINK_PROTOCOL_W = 2;
    localparam int MANTISSA_LSB = 16;
    localparam int MANTISSA_W = 16;

    // Sublink type: bit 0 asymmetric, bit 1 transmit direction
    localparam logic [SUBLINK_TYPE_W-1:0] SUBLINK_TYPE_SYM_RX = 2'h0;
    localparam logic [SUBLINK_TYPE_W-1:0] SUBLINK_TYPE_SYM_TX = 2'h2;
    localparam logic [LINK_PROTOCOL_W-1:0] LINK_PROTOCOL_PLUS_RATE = 2'h1;

    localparam logic [EXPONENT_W-1:0] EXPONENT_BPS = 2'h0;
    localparam logic [EXPONENT_W-1:0] EXPONENT_KBPS = 2'h1;
    localparam logic [EXPONENT_W-1:0] EXPONENT_MBPS = 2'h2;
    localparam logic [EXPONENT_W-1:0] EXPONENT_GBPS = 2'h3;

    localparam int DW_COUNT = 3;
    localparam int DW_IDX_W = 2;

    // Lane rate reported in both notifications
    typedef struct packed {
        logic [MANTISSA_W-1:0] mantissa;
        logic [EXPONENT_W-1:0] exponent;
        logic [LANES_W-1:0] lane_count;
    } srn_rate_t;

    // One dword on the outgoing packet stream
    typedef struct packed {
        logic [31:0] data;
        logic sop;
        logic eop;
    } srn_beat_t;

    typedef enum logic [4:0] {
        SRN_IDLE = 5'b00001,
        SRN_WAIT_ACK = 5'b00010,
        SRN_SEND_RX = 5'b00100,
        SRN_SEND_TX = 5'b01000,
        SRN_DONE = 5'b10000
    } srn_state_t;

endpackage

// ### rtl/srn_dword_builder.sv
// Builds one dword of a sublink speed notification packet
`timescale 1ns/1ns
`default_nettype none
module srn_dword_builder
    import srn_pkg::*;
(
    input wire logic [DW_IDX_W-1:0] dw_idx,
    input wire logic tx_dir,
    input wire logic [DEV_ADDR_W-1:0] dev_addr,
    input wire srn_rate_t rate,
    output logic [31:0] dword
);

    wire [31:0] dw0;
    wire [31:0] dw1;
    wire [31:0] dw2;
    wire [SUBLINK_TYPE_W-1:0] sublink_type_code;

    assign sublink_type_code = tx_dir ? SUBLINK_TYPE_SYM_TX : SUBLINK_TYPE_SYM_RX;

    assign dw0 = (32'(dev_addr) << DEV_ADDR_LSB) | (32'(TP_TYPE_CODE) << TYPE_LSB);

    assign dw1 = (32'(!tx_dir) << FOLLOW_BIT)
        | (32'(SUBLINK_SPEED_NOTE) << NOTE_TYPE_LSB)
        | (32'(DEVICE_NOTICE_SUBTYPE) << SUBTYPE_LSB);

    // Rate fields, shared by both directions so the link stays symmetric
    assign dw2 = (32'(rate.mantissa) << MANTISSA_LSB)
        | (32'(LINK_PROTOCOL_PLUS_RATE) << LINK_PROTOCOL_LSB)
        | (32'(rate.lane_count) << LANES_LSB)
        | (32'(sublink_type_code) << SUBLINK_TYPE_LSB)
        | (32'(rate.exponent) << EXPONENT_LSB);

    assign dword = (dw_idx == 2'h0) ? dw0 : (dw_idx == 2'h1) ? dw1 : dw2;

endmodule
`default_nettype wire

// ### rtl/srn_notifier.sv
// Sublink rate notifier: sends the receive and transmit speed notices after addressing
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - In the plus-rate mode the pair of notices is produced on entering the Address state.
// - Lane speed is mantissa times 1000 to the power of the exponent field.
// - Sublink speed is lane speed times lane count plus one.
// - The status-stage acknowledgement after a set-address carries the following flag.
// - The first packet sent after that acknowledgement is the receive-direction notice.
// - The receive notice carries the following flag and the transmit notice comes next.
// - Only symmetric links are reported, same rate and lanes in both directions.
// - Dword 1 holds the subtype code at bit 0 and notice type code at bit 4.
// - The 2-bit exponent at dword 2 bit 4 picks the base-1000 unit of the mantissa.
// - The lane count is zero based, zero meaning a single lane.
module srn_notifier
    import srn_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic plus_rate_mode,
    input wire logic set_address_seen,
    input wire logic [DEV_ADDR_W-1:0] dev_addr,
    input wire logic addressed_state,
    input wire srn_rate_t lane_rate,
    input wire logic status_ack_sent,
    output logic status_ack_follow,
    output srn_beat_t tp_beat,
    output logic tp_valid,
    input wire logic tp_ready,
    output logic notify_busy
);

    // ----------------------------------------
    // State and datapath registers
    // ----------------------------------------
    srn_state_t state_r;
    srn_state_t state_nxt;
    logic [DW_IDX_W-1:0] dw_idx_r;
    logic [DW_IDX_W-1:0] dw_idx_nxt;
    logic addr_state_d_r;
    srn_rate_t rate_r;
    logic [31:0] dword;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    // States that put notice dwords on the stream
    function automatic logic is_sending(input srn_state_t s);
        return (s == SRN_SEND_RX) || (s == SRN_SEND_TX);
    endfunction

    // Index of the closing dword of a notice
    function automatic logic is_last_dword(input logic [DW_IDX_W-1:0] idx);
        return idx == DW_IDX_W'(DW_COUNT - 1);
    endfunction

    // ----------------------------------------
    // Start and direction decodes
    // ----------------------------------------
    wire beat_done = tp_valid && tp_ready;
    wire last_dw = is_last_dword(dw_idx_r);
    wire enter_address = addressed_state && !addr_state_d_r;
    wire start_req = set_address_seen || enter_address;
    wire start = plus_rate_mode && start_req;
    wire idle_start = (state_r == SRN_IDLE) && start;
    wire tx_dir_nxt = state_nxt == SRN_SEND_TX;

    srn_dword_builder u_builder (
        .dw_idx(dw_idx_nxt),
        .tx_dir(tx_dir_nxt),
        .dev_addr(dev_addr),
        .rate(rate_r),
        .dword(dword)
    );

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_comb begin
        state_nxt = state_r;
        dw_idx_nxt = dw_idx_r;
        if (beat_done) begin
            dw_idx_nxt = last_dw ? '0 : dw_idx_r + 1'b1;
        end
        case (state_r)
            SRN_IDLE: begin
                if (start) begin
                    state_nxt = SRN_WAIT_ACK;
                end
            end
            SRN_WAIT_ACK: begin
                if (status_ack_sent) begin
                    state_nxt = SRN_SEND_RX;
                    dw_idx_nxt = '0;
                end
            end
            SRN_SEND_RX: begin
                if (beat_done && last_dw) begin
                    state_nxt = SRN_SEND_TX;
                end
            end
            SRN_SEND_TX: begin
                if (beat_done && last_dw) begin
                    state_nxt = SRN_DONE;
                end
            end
            SRN_DONE: begin
                if (!addressed_state) begin
                    state_nxt = SRN_IDLE;
                end
            end
            default: begin
                state_nxt = SRN_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Stream and flag decodes
    // ----------------------------------------
    wire sending_nxt = is_sending(state_nxt);
    wire load_beat = sending_nxt && (!tp_valid || beat_done);
    wire first_dw_nxt = dw_idx_nxt == '0;
    wire last_dw_nxt = is_last_dword(dw_idx_nxt);
    wire busy_nxt = (state_nxt != SRN_IDLE) && (state_nxt != SRN_DONE);
    wire follow_nxt = state_nxt == SRN_WAIT_ACK;

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= SRN_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------
    // Dword index
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dw_idx_r <= '0;
        end else begin
            dw_idx_r <= dw_idx_nxt;
        end
    end

    // ----------------------------------------
    // Address state edge detect
    // ----------------------------------------
    // Resets to the idle level so no false start follows reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            addr_state_d_r <= 1'b0;
        end else begin
            addr_state_d_r <= addressed_state;
        end
    end

    // ----------------------------------------
    // Lane rate capture
    // ----------------------------------------
    // One capture feeds both notices, keeping the pair symmetric
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rate_r <= '0;
        end else if (idle_start) begin
            rate_r <= lane_rate;
        end
    end

    // ----------------------------------------
    // Outgoing stream valid
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tp_valid <= 1'b0;
        end else if (load_beat) begin
            tp_valid <= 1'b1;
        end else if (beat_done) begin
            tp_valid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Dword payload
    // ----------------------------------------
    // Held while the host stalls, reloaded only into an empty or accepted slot
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tp_beat <= '0;
        end else if (load_beat) begin
            tp_beat.data <= dword;
            tp_beat.sop <= first_dw_nxt;
            tp_beat.eop <= last_dw_nxt;
        end
    end

    // ----------------------------------------
    // Busy flag
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            notify_busy <= 1'b0;
        end else begin
            notify_busy <= busy_nxt;
        end
    end

    // ----------------------------------------
    // Status-stage follow flag
    // ----------------------------------------
    // Drops at the edge that sees the acknowledgement, so it marks one stage only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_ack_follow <= 1'b0;
        end else begin
            status_ack_follow <= follow_nxt;
        end
    end

endmodule
`default_nettype wire

// ### tb/srn_notifier_properties.sv
// Assertions on the sublink rate notifier ports
`timescale 1ns/1ns
`default_nettype none
module srn_notifier_properties
    import srn_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic plus_rate_mode,
    input wire logic set_address_seen,
    input wire logic [DEV_ADDR_W-1:0] dev_addr,
    input wire logic addressed_state,
    input wire srn_rate_t lane_rate,
    input wire logic status_ack_sent,
    input wire logic status_ack_follow,
    input wire srn_beat_t tp_beat,
    input wire logic tp_valid,
    input wire logic tp_ready,
    input wire logic notify_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----
    // Tracks whether the transmit notice is on the wire
    // ----
    logic tx_r;
    logic tx_nxt;
    wire hs = tp_valid && tp_ready;
    wire mid = tp_valid && !tp_beat.sop && !tp_beat.eop;
    wire [31:0] d = tp_beat.data;
    assign tx_nxt = !notify_busy ? 1'b0 : (hs && tp_beat.eop) ? !tx_r : tx_r;
    always_ff @(posedge clk) tx_r <= reset_n ? tx_nxt : 1'b0;
    a_start_flags: assert property ($rose(notify_busy) |-> status_ack_follow)
        else $error("start without follow flag");
    a_mode_gate: assert property (!plus_rate_mode && !notify_busy |=> !notify_busy)
        else $error("start outside plus-rate mode");
    a_ack_then_rx: assert property (status_ack_sent && status_ack_follow |=>
        tp_valid && tp_beat.sop && !status_ack_follow)
        else $error("receive notice not next");
    a_tx_follows: assert property (hs && tp_beat.eop && !tx_r |=> tp_valid && tp_beat.sop)
        else $error("transmit notice not next");
    a_beat_hold: assert property (tp_valid && !tp_ready |=> tp_valid && $stable(tp_beat))
        else $error("beat changed while stalled");
    a_word1_codes: assert property (mid |->
        d[7:0] == {SUBLINK_SPEED_NOTE, DEVICE_NOTICE_SUBTYPE} && d[31] == !tx_r)
        else $error("dword 1 wrong");
    a_word2_rate: assert property (tp_valid && tp_beat.eop |-> d[5:4] == lane_rate.exponent
        && d[13:10] == lane_rate.lane_count && d[31:16] == lane_rate.mantissa)
        else $error("dword 2 rate wrong");
    a_sym_type: assert property (tp_valid && tp_beat.eop |->
        d[7:6] == (tx_r ? SUBLINK_TYPE_SYM_TX : SUBLINK_TYPE_SYM_RX))
        else $error("sublink type wrong");
    a_idle_quiet: assert property (!notify_busy |-> !tp_valid)
        else $error("valid while idle");
    c_start: cover property ($rose(notify_busy));
    c_stall: cover property (tp_valid && !tp_ready);
    c_tx_end: cover property (hs && tp_beat.eop && tx_r);
endmodule
`default_nettype wire

// ### tb/srn_host_model.sv
// Host-side partner: acknowledges the status stage and accepts dwords
`timescale 1ns/1ns
`default_nettype none
module srn_host_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic status_ack_follow,
    input wire logic stall,
    output logic status_ack_sent,
    output logic tp_ready
);
    // One acknowledgement per flagged status stage
    always_ff @(posedge clk) status_ack_sent <= reset_n && status_ack_follow && !status_ack_sent;
    assign tp_ready = !stall;
endmodule
`default_nettype wire

// ### tb/srn_notifier_tb.sv
// Self-checking bench for the sublink rate notifier
`timescale 1ns/1ns
`default_nettype none
module srn_notifier_tb
    import srn_pkg::*;
;
    logic clk = 0, reset_n = 0, plus_rate_mode = 0, set_address_seen = 0, addressed_state = 0;
    logic stall = 0, slow = 0, status_ack_sent, status_ack_follow, tp_valid, tp_ready, notify_busy;
    logic [DEV_ADDR_W-1:0] dev_addr = '0;
    srn_rate_t lane_rate = '0;
    srn_beat_t tp_beat;
    logic [31:0] seed = 32'h0000_002e, rs = '0;
    logic [33:0] exp_q[$];
    int miscompares = 0, num_checks = 0;
    srn_notifier i_srn_notifier(.clk(clk), .reset_n(reset_n), .plus_rate_mode(plus_rate_mode),
        .set_address_seen(set_address_seen), .dev_addr(dev_addr),
        .addressed_state(addressed_state), .lane_rate(lane_rate),
        .status_ack_sent(status_ack_sent), .status_ack_follow(status_ack_follow),
        .tp_beat(tp_beat), .tp_valid(tp_valid), .tp_ready(tp_ready), .notify_busy(notify_busy));
    srn_host_model i_srn_host_model(.clk(clk), .reset_n(reset_n), .stall(stall),
        .status_ack_follow(status_ack_follow), .status_ack_sent(status_ack_sent),
        .tp_ready(tp_ready));
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(string n, logic [33:0] e, logic [33:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_flag(string n, logic e, logic g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    task summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task push_note(logic tx);
        exp_q.push_back({dev_addr, 20'h0_0000, TP_TYPE_CODE, 2'h2});
        exp_q.push_back({!tx, 23'h00_0000, SUBLINK_SPEED_NOTE, DEVICE_NOTICE_SUBTYPE, 2'h0});
        exp_q.push_back({lane_rate.mantissa, LINK_PROTOCOL_PLUS_RATE, lane_rate.lane_count,
            2'h0, tx ? SUBLINK_TYPE_SYM_TX : SUBLINK_TYPE_SYM_RX, lane_rate.exponent, 4'h0,
            2'h1});
    endtask
    task run(int k);
        int n;
        n = 0;
        @(posedge clk);
        dev_addr <= rs[6:0];
        lane_rate <= '{rs[31:16], k[1:0], rs[11:8]};
        plus_rate_mode <= (k != 3);
        slow <= k >= 4;
        @(posedge clk);
        if (k[0]) set_address_seen <= 1'b1;
        else addressed_state <= 1'b1;
        @(posedge clk);
        set_address_seen <= 1'b0;
        if (k != 3) begin
            push_note(1'b0);
            push_note(1'b1);
        end
        while ((n < 4 || exp_q.size() > 0 || notify_busy !== 1'b0) && n < 200) begin
            @(posedge clk);
            set_address_seen <= (n == 3);
            n++;
            @(negedge clk);
        end
        chk("idle", 34'h0_0000_0000, {33'h0_0000_0000, notify_busy});
        @(posedge clk);
        addressed_state <= 1'b0;
        set_address_seen <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    always @(negedge clk) rs = xs();
    always @(posedge clk) stall <= slow && rs[0];
    always @(posedge clk) begin
        if (reset_n && tp_valid && tp_ready) begin
            if (exp_q.size() == 0) chk("extra beat", '0, tp_beat);
            else chk("beat", exp_q.pop_front(), tp_beat);
        end
        if (reset_n && status_ack_sent) chk_flag("ack follow", 1'b1, status_ack_follow);
        if (reset_n && tp_valid && tp_beat.sop) begin
            chk_flag("follow clear", 1'b0, status_ack_follow);
        end
    end
    initial forever #10 clk = !clk;
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 8; k++) run(k);
        summarize();
    end
endmodule
bind srn_notifier srn_notifier_properties i_srn_notifier_properties(.clk(clk),
    .reset_n(reset_n), .plus_rate_mode(plus_rate_mode), .set_address_seen(set_address_seen),
    .dev_addr(dev_addr), .addressed_state(addressed_state), .lane_rate(lane_rate),
    .status_ack_sent(status_ack_sent), .status_ack_follow(status_ack_follow),
    .tp_beat(tp_beat), .tp_valid(tp_valid), .tp_ready(tp_ready), .notify_busy(notify_busy));
`default_nettype wire
